// ==== rtl/dpsw_consts.svh ====
// Register offsets, field positions, reset values and counts for the pipe control block
`ifndef DPSW_CONSTS_SVH
`define DPSW_CONSTS_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define DPSW_STBY_CTRL_OFS 32'h5800_1858
`define DPSW_MW_ATTR_OFS 32'h5800_1900
`define DPSW_VP0_ATTR_OFS 32'h5800_1910
`define DPSW_VP1_ATTR_OFS 32'h5800_1914
`define DPSW_VP2_ATTR_OFS 32'h5800_1918
`define DPSW_MWCTL_OFS 32'h5800_1920
`define DPSW_IRQ_STAT_OFS 32'h5800_1930
`define DPSW_IRQ_MASK_OFS 32'h5800_1934
`define DPSW_STATUS_OFS 32'h5800_1938
// ----------------------------------------
// Field positions
// ----------------------------------------
`define DPSW_ENH_OFF_BIT 0
`define DPSW_ENABLE_BIT 0
`define DPSW_MEM_MODE_BIT 19
`define DPSW_SRC_LSB 1
`define DPSW_MW_DONE_BIT 0
`define DPSW_SYNC_LOST_BIT 1
`define DPSW_UNDERFLOW_BIT 2
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define DPSW_STBY_RESET 32'h0000_0000
`define DPSW_ATTR_RESET 32'h0000_0000
`define DPSW_IRQ_W 3
`define DPSW_NUM_PIPES 3
`define DPSW_FRAME_CYCLES 16'h0400
`endif

// ==== rtl/dpsw_pkg.sv ====
// Types shared by the pipe standby and memory writer control block
package dpsw_pkg;
    // Register bus request
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dpsw_req_t;
    // Memory writer sequencing states
    typedef enum logic [1:0] {
        DPSW_IDLE,
        DPSW_RUN,
        DPSW_DONE
    } dpsw_mw_state_t;
endpackage

// ==== rtl/dpsw_ctl.sv ====
// Standby enhancement and memory writer path control for the display subsystem pipes
//
// Operation
// - Enhanced standby ignores non-optimal DMA thresholds.
// - Standby control bit 0: one turns enhancement off.
// - Writer attributes bit 19 selects memory-to-memory.
// - Completion clears writer enable, pipe stays enabled.
// - Unaligned on-the-fly redirect raises sync lost.
// - Pipe attributes bit 0 enables the pipe.
`timescale 1ns/100ps
`include "dpsw_consts.svh"

module dpsw_ctl #(
    parameter int NPIPE = `DPSW_NUM_PIPES,
    parameter logic [15:0] FRAME_CYCLES = `DPSW_FRAME_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire dpsw_pkg::dpsw_req_t busReq,
    output logic [31:0] busRdata,
    input wire logic smartStandby,
    input wire logic dmaThreshOk,
    input wire logic pipeIdle,
    input wire logic frameStart,
    input wire logic mwFrameDone,
    output logic standbyAck,
    output logic [NPIPE-1:0] pipeEnable,
    output logic [NPIPE-1:0] pipeToPanel,
    output logic mwEnable,
    output logic mwMemMode,
    output logic irq
);
    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic enhOff_reg; // Enhancement turned off
    logic [31:0] mwAttr_reg; // Memory writer attributes
    logic [31:0] vpAttr_reg [NPIPE]; // Video pipe attributes
    logic [NPIPE-1:0] vpToPanel_reg; // Pipe routed to panel, not writer
    logic [`DPSW_IRQ_W-1:0] irqStat_reg; // Sticky events
    logic [`DPSW_IRQ_W-1:0] irqMask_reg; // Event mask
    logic [31:0] rdata_reg; // Read data, one cycle late
    dpsw_pkg::dpsw_mw_state_t mwState_reg;
    logic [15:0] frameCnt_reg; // Cycles elapsed in writer run
    logic [NPIPE-1:0] frameAligned_reg; // Pipe's panel frame started
    logic mwDoneEv; // Writer run completes this cycle
    logic syncLostEv; // Unaligned redirect seen
    logic underflowEv; // Multi-pipe smart-standby hazard
    logic standbyOk; // Standby condition
    logic [NPIPE-1:0] pipeEnVec; // Enable bits gathered
    logic [1:0] pipesOn; // Count of enabled pipes
    logic wrStby, wrMw, wrCtl, wrStat, wrMask;

    assign wrStby = busReq.wr && busReq.addr == `DPSW_STBY_CTRL_OFS;
    assign wrMw = busReq.wr && busReq.addr == `DPSW_MW_ATTR_OFS;
    assign wrCtl = busReq.wr && busReq.addr == `DPSW_MWCTL_OFS;
    assign wrStat = busReq.wr && busReq.addr == `DPSW_IRQ_STAT_OFS;
    assign wrMask = busReq.wr && busReq.addr == `DPSW_IRQ_MASK_OFS;

    // ----------------------------------------
    // Standby enhancement control
    // ----------------------------------------
    // Bit 0 only; other bits read as zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enhOff_reg <= 1'b0;
        end else if (wrStby) begin
            enhOff_reg <= busReq.wdata[`DPSW_ENH_OFF_BIT];
        end
    end

    // Count enabled pipes for the standby hazard
    always_comb begin
        pipesOn = 2'd0;
        for (int i = 0; i < NPIPE; i++) begin
            pipeEnVec[i] = vpAttr_reg[i][`DPSW_ENABLE_BIT];
            if (pipeEnVec[i] && pipesOn != 2'd3) begin
                pipesOn = pipesOn + 2'd1;
            end
        end
    end

    // Enhanced mode skips the threshold check, legacy mode needs it
    assign standbyOk = pipeIdle && (!enhOff_reg || dmaThreshOk);
    // Enhancement left on with several pipes in smart standby underflows
    assign underflowEv = smartStandby && !enhOff_reg && pipesOn > 2'd1 && standbyAck;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            standbyAck <= 1'b0;
        end else begin
            standbyAck <= smartStandby && standbyOk;
        end
    end

    // ----------------------------------------
    // Memory writer attributes and sequencing
    // ----------------------------------------
    // Hardware clear of enable beats a software write in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mwAttr_reg <= `DPSW_ATTR_RESET;
        end else begin
            if (wrMw) begin
                mwAttr_reg <= busReq.wdata;
            end
            if (mwDoneEv) begin
                mwAttr_reg[`DPSW_ENABLE_BIT] <= 1'b0;
            end
        end
    end

    // Run lasts until the writer reports the frame written or the count reaches FRAME_CYCLES
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mwState_reg <= dpsw_pkg::DPSW_IDLE;
            frameCnt_reg <= 16'h0000;
        end else begin
            case (mwState_reg)
                dpsw_pkg::DPSW_IDLE: begin
                    // Memory mode run starts on enable
                    if (mwAttr_reg[`DPSW_ENABLE_BIT] && mwAttr_reg[`DPSW_MEM_MODE_BIT]) begin
                        mwState_reg <= dpsw_pkg::DPSW_RUN;
                        frameCnt_reg <= 16'h0000;
                    end
                end
                dpsw_pkg::DPSW_RUN: begin
                    // Timeout guards a writer that never reports
                    if (mwFrameDone || frameCnt_reg == FRAME_CYCLES) begin
                        mwState_reg <= dpsw_pkg::DPSW_DONE;
                    end else begin
                        frameCnt_reg <= frameCnt_reg + 16'h0001;
                    end
                end
                dpsw_pkg::DPSW_DONE: begin
                    // Wait for enable low before a new run
                    if (!mwAttr_reg[`DPSW_ENABLE_BIT]) begin
                        mwState_reg <= dpsw_pkg::DPSW_IDLE;
                    end
                end
                default: begin
                    mwState_reg <= dpsw_pkg::DPSW_IDLE;
                end
            endcase
        end
    end

    assign mwDoneEv = mwState_reg == dpsw_pkg::DPSW_RUN
        && (mwFrameDone || frameCnt_reg == FRAME_CYCLES);

    // ----------------------------------------
    // Video pipe attributes and routing
    // ----------------------------------------
    // Enable untouched by writer completion
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NPIPE; i++) begin
                vpAttr_reg[i] <= `DPSW_ATTR_RESET;
            end
        end else begin
            for (int i = 0; i < NPIPE; i++) begin
                if (busReq.wr && busReq.addr == `DPSW_VP0_ATTR_OFS + 32'(4 * i)) begin
                    vpAttr_reg[i] <= busReq.wdata;
                end
            end
        end
    end

    // Routing register: bit per pipe, one means panel
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            vpToPanel_reg <= '0;
        end else if (wrCtl) begin
            vpToPanel_reg <= busReq.wdata[`DPSW_SRC_LSB +: NPIPE];
        end
    end

    // Panel frame alignment: a redirect only lines up after a frame start
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frameAligned_reg <= '0;
        end else begin
            for (int i = 0; i < NPIPE; i++) begin
                if (!pipeEnVec[i] || !vpToPanel_reg[i]) begin
                    frameAligned_reg[i] <= 1'b0;
                end else if (frameStart) begin
                    frameAligned_reg[i] <= 1'b1;
                end
            end
        end
    end

    // Redirect of a live pipe is not frame aligned
    always_comb begin
        syncLostEv = 1'b0;
        for (int i = 0; i < NPIPE; i++) begin
            if (wrCtl && pipeEnVec[i] && !vpToPanel_reg[i]
                && busReq.wdata[`DPSW_SRC_LSB + i]) begin
                syncLostEv = 1'b1;
            end
        end
    end

    // Outputs registered
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pipeEnable <= '0;
            pipeToPanel <= '0;
            mwEnable <= 1'b0;
            mwMemMode <= 1'b0;
        end else begin
            pipeEnable <= pipeEnVec;
            pipeToPanel <= vpToPanel_reg;
            mwEnable <= mwAttr_reg[`DPSW_ENABLE_BIT] && !mwDoneEv;
            mwMemMode <= mwAttr_reg[`DPSW_MEM_MODE_BIT];
        end
    end

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    // Set wins over write-one-to-clear so no event is lost
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irqStat_reg <= '0;
        end else begin
            irqStat_reg <= (irqStat_reg & ~(wrStat ? busReq.wdata[`DPSW_IRQ_W-1:0] : '0))
                | {underflowEv, syncLostEv, mwDoneEv};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irqMask_reg <= '0;
        end else if (wrMask) begin
            irqMask_reg <= busReq.wdata[`DPSW_IRQ_W-1:0];
        end
    end

    // Level interrupt, one cycle behind the status
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStat_reg & irqMask_reg);
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Unmapped addresses read zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (busReq.rd) begin
            rdata_reg <= 32'h0000_0000;
            case (busReq.addr)
                `DPSW_STBY_CTRL_OFS: rdata_reg <= {31'h0000_0000, enhOff_reg};
                `DPSW_MW_ATTR_OFS: rdata_reg <= mwAttr_reg;
                `DPSW_VP0_ATTR_OFS: rdata_reg <= vpAttr_reg[0];
                `DPSW_VP1_ATTR_OFS: rdata_reg <= vpAttr_reg[1];
                `DPSW_VP2_ATTR_OFS: rdata_reg <= vpAttr_reg[2];
                `DPSW_MWCTL_OFS: rdata_reg <= 32'({vpToPanel_reg, 1'b0});
                `DPSW_IRQ_STAT_OFS: rdata_reg <= 32'(irqStat_reg);
                `DPSW_IRQ_MASK_OFS: rdata_reg <= 32'(irqMask_reg);
                `DPSW_STATUS_OFS: rdata_reg <= 32'({frameAligned_reg, mwState_reg});
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end
    assign busRdata = rdata_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_enh_bit;
        @(posedge clk) disable iff (!arst_n)
        wrStby |=> enhOff_reg == $past(busReq.wdata[0]);
    endproperty
    a_enh_bit: assert property (p_enh_bit) else $error("standby bit not stored");

    property p_enh_standby;
        @(posedge clk) disable iff (!arst_n)
        smartStandby && pipeIdle && !enhOff_reg |=> standbyAck;
    endproperty
    a_enh_standby: assert property (p_enh_standby) else $error("no enhanced standby");

    property p_mem_mode;
        @(posedge clk) disable iff (!arst_n)
        wrMw ##1 1'b1 |=> mwMemMode == $past(busReq.wdata[19], 2);
    endproperty
    a_mem_mode: assert property (p_mem_mode) else $error("memory mode wrong");

    property p_mem_start;
        @(posedge clk) disable iff (!arst_n)
        mwState_reg == dpsw_pkg::DPSW_IDLE && mwAttr_reg[0] && mwAttr_reg[19]
            |=> mwState_reg == dpsw_pkg::DPSW_RUN;
    endproperty
    a_mem_start: assert property (p_mem_start) else $error("writer run not started");

    property p_legacy_stby;
        @(posedge clk) disable iff (!arst_n)
        enhOff_reg && !dmaThreshOk |=> !standbyAck;
    endproperty
    a_legacy_stby: assert property (p_legacy_stby) else $error("legacy standby");

    property p_underflow;
        @(posedge clk) disable iff (!arst_n)
        smartStandby && !enhOff_reg && pipesOn > 2'd1 && standbyAck |=> irqStat_reg[2];
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow not flagged");

    property p_done_clear;
        @(posedge clk) disable iff (!arst_n)
        mwDoneEv |=> !mwAttr_reg[0] ##1 !mwEnable;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("writer enable kept");

    property p_pipe_kept;
        @(posedge clk) disable iff (!arst_n)
        mwDoneEv && !busReq.wr |=> pipeEnVec == $past(pipeEnVec);
    endproperty
    a_pipe_kept: assert property (p_pipe_kept) else $error("pipe enable changed");

    property p_sync_lost;
        @(posedge clk) disable iff (!arst_n)
        syncLostEv |=> irqStat_reg[1];
    endproperty
    a_sync_lost: assert property (p_sync_lost) else $error("sync lost not flagged");

    property p_pipe_en;
        @(posedge clk) disable iff (!arst_n)
        busReq.wr && busReq.addr == `DPSW_VP0_ATTR_OFS ##1 1'b1
            |=> pipeEnable[0] == $past(busReq.wdata[0], 2);
    endproperty
    a_pipe_en: assert property (p_pipe_en) else $error("pipe enable wrong");

    property p_irq_level;
        @(posedge clk) disable iff (!arst_n)
        |(irqStat_reg & irqMask_reg) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt missing");

    c_mem_done: cover property (@(posedge clk) disable iff (!arst_n) mwDoneEv);
    c_aligned: cover property (@(posedge clk) disable iff (!arst_n) |frameAligned_reg);
    c_sync_lost: cover property (@(posedge clk) disable iff (!arst_n) syncLostEv);
    c_underflow: cover property (@(posedge clk) disable iff (!arst_n) underflowEv);
endmodule

// ==== verif/dpsw_far_model.sv ====
// Far side model: panel frame starts and memory writer completion
`timescale 1ns/100ps
module dpsw_far_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic mwEnable,
    input wire logic [7:0] lag,
    output logic frameStart,
    output logic mwFrameDone
);
    logic [7:0] frmCnt; // Panel frame period counter
    logic [7:0] runCnt; // Cycles since the writer was enabled
    // ----------------------------------------
    // Panel frame starts
    // ----------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frmCnt <= 8'h00;
            frameStart <= 1'b0;
        end else begin
            frmCnt <= frmCnt + 8'h01;
            frameStart <= (frmCnt == 8'h3F); // One-cycle pulse
        end
    end
    // ----------------------------------------
    // Writer completion
    // ----------------------------------------
    // A lag beyond the design's run limit leaves completion to its timeout
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            runCnt <= 8'h00;
            mwFrameDone <= 1'b0;
        end else begin
            runCnt <= mwEnable ? runCnt + 8'h01 : 8'h00;
            mwFrameDone <= mwEnable && (runCnt == lag); // Never pulses once disabled
        end
    end
endmodule

// ==== verif/test_display_pipe_standby_and_writeback_ctl.sv ====
// Self-checking bench for the pipe standby and memory writer control block
`timescale 1ns/100ps
`include "dpsw_consts.svh"
module test_display_pipe_standby_and_writeback_ctl;
    logic clk;
    logic arst_n;
    dpsw_pkg::dpsw_req_t busReq; // Register bus request
    logic [31:0] busRdata;
    logic smartStandby, dmaThreshOk, pipeIdle, frameStart, mwFrameDone;
    logic standbyAck, mwEnable, mwMemMode, irq;
    logic [2:0] pipeEnable, pipeToPanel;
    logic [7:0] lag; // Writer completion delay in the far model
    int error_cnt;
    int comparisons;
    int cycleCnt; // Hang guard
    // ----------------------------------------
    // Design and far side
    // ----------------------------------------
    dpsw_ctl #(.NPIPE(3), .FRAME_CYCLES(16'h0010)) dpsw_ctl_i (.clk(clk), .arst_n(arst_n),
        .busReq(busReq), .busRdata(busRdata), .smartStandby(smartStandby),
        .dmaThreshOk(dmaThreshOk), .pipeIdle(pipeIdle), .frameStart(frameStart),
        .mwFrameDone(mwFrameDone), .standbyAck(standbyAck), .pipeEnable(pipeEnable),
        .pipeToPanel(pipeToPanel), .mwEnable(mwEnable), .mwMemMode(mwMemMode), .irq(irq));
    dpsw_far_model dpsw_far_model_i (.clk(clk), .arst_n(arst_n), .mwEnable(mwEnable),
        .lag(lag), .frameStart(frameStart), .mwFrameDone(mwFrameDone));
    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Whole run needs well under 1000 cycles
    always @(posedge clk) begin
        cycleCnt++;
        if (cycleCnt == 5000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic end_of_test();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrReg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0; // Strobe taken at this edge
    endtask
    // Data stand from the edge that takes the strobe until the next read
    task automatic rdReg(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1 d = busRdata;
    endtask
    task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rdReg(a, d);
        chk(d, exp);
    endtask
    task automatic waitCyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rdChk(`DPSW_STBY_CTRL_OFS, `DPSW_STBY_RESET);
        rdChk(`DPSW_MW_ATTR_OFS, `DPSW_ATTR_RESET);
        rdChk(`DPSW_VP2_ATTR_OFS, `DPSW_ATTR_RESET);
        rdChk(32'h5800_1FFC, 32'h0000_0000); // Unmapped place reads zero
        chk({29'h0, pipeEnable}, 32'h0000_0000);
    endtask
    task automatic t_standby();
        smartStandby <= 1'b1;
        pipeIdle <= 1'b1;
        waitCyc(3);
        chk({31'h0, standbyAck}, 32'h1);
        wrReg(`DPSW_STBY_CTRL_OFS, 32'h0000_0001);
        waitCyc(2);
        chk({31'h0, standbyAck}, 32'h0);
        rdChk(`DPSW_STBY_CTRL_OFS, 32'h0000_0001);
        dmaThreshOk <= 1'b1;
        waitCyc(3);
        chk({31'h0, standbyAck}, 32'h1);
        dmaThreshOk <= 1'b0;
        smartStandby <= 1'b0;
        wrReg(`DPSW_STBY_CTRL_OFS, 32'h0000_0000);
    endtask
    task automatic t_pipes();
        logic [2:0] exp;
        exp = 3'b000;
        for (int i = 0; i < 3; i++) begin
            wrReg(`DPSW_VP0_ATTR_OFS + 32'(4 * i), 32'h0000_0001);
            exp[i] = 1'b1;
            waitCyc(2);
            chk({29'h0, pipeEnable}, {29'h0, exp});
        end
        // Several pipes in smart standby with enhancement on flag the hazard
        smartStandby <= 1'b1;
        waitCyc(3);
        smartStandby <= 1'b0;
        rdChk(`DPSW_IRQ_STAT_OFS, 32'h0000_0004);
        wrReg(`DPSW_IRQ_STAT_OFS, 32'h0000_0004);
        wrReg(`DPSW_VP1_ATTR_OFS, 32'h0000_0000);
        wrReg(`DPSW_VP2_ATTR_OFS, 32'h0000_0000);
        waitCyc(2);
        chk({29'h0, pipeEnable}, 32'h1);
    endtask
    // Prompt completion by the far side, or by the design's timeout for a long lag
    task automatic t_mem_run(input logic [7:0] lagV);
        int n;
        lag <= lagV;
        wrReg(`DPSW_IRQ_MASK_OFS, 32'h0000_0001);
        wrReg(`DPSW_MW_ATTR_OFS, 32'h0008_0001);
        waitCyc(2);
        chk({30'h0, mwMemMode, mwEnable}, 32'h3);
        // Look at the enable only once it has settled after each edge
        for (n = 0; n < 40 && mwEnable !== 1'b0; n++) begin
            waitCyc(1);
        end
        #1 chk({31'h0, mwEnable}, 32'h0);
        rdChk(`DPSW_MW_ATTR_OFS, 32'h0008_0000);
        chk({29'h0, pipeEnable}, 32'h1);
        waitCyc(2);
        chk({31'h0, irq}, 32'h1); // Unmasked done raises the interrupt
        wrReg(`DPSW_IRQ_STAT_OFS, 32'h0000_0001);
        waitCyc(2);
        chk({31'h0, irq}, 32'h0); // Write one to clear
    endtask
    task automatic t_redirect();
        logic [31:0] d;
        wrReg(`DPSW_MWCTL_OFS, 32'h0000_0002);
        waitCyc(2);
        rdChk(`DPSW_IRQ_STAT_OFS, 32'h0000_0002);
        chk({29'h0, pipeToPanel}, 32'h1);
        wrReg(`DPSW_IRQ_STAT_OFS, 32'h0000_0002);
        wrReg(`DPSW_STBY_CTRL_OFS, 32'h0000_0001);
        // Pipe 1 feeds the writer, so skipping the exit steps would lose sync
        wrReg(`DPSW_VP1_ATTR_OFS, 32'h0000_0001);
        wrReg(`DPSW_VP1_ATTR_OFS, 32'h0000_0000);
        wrReg(`DPSW_MW_ATTR_OFS, 32'h0008_0001);
        wrReg(`DPSW_MW_ATTR_OFS, 32'h0008_0000);
        wrReg(`DPSW_MWCTL_OFS, 32'h0000_0006);
        wrReg(`DPSW_VP1_ATTR_OFS, 32'h0000_0001);
        waitCyc(2);
        rdReg(`DPSW_IRQ_STAT_OFS, d);
        chk(d & 32'h0000_0002, 32'h0000_0000);
        chk({29'h0, pipeEnable}, 32'h3);
        // A panel frame start aligns both routed pipes; writer back to idle
        waitCyc(260);
        rdChk(`DPSW_STATUS_OFS, 32'h0000_000C);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        arst_n = 1'b0;
        busReq = '0;
        smartStandby = 1'b0;
        dmaThreshOk = 1'b0;
        pipeIdle = 1'b0;
        lag = 8'h03;
        error_cnt = 0;
        comparisons = 0;
        cycleCnt = 0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_standby();
        t_pipes();
        t_mem_run(8'h03);
        t_mem_run(8'h28);
        t_redirect();
        end_of_test();
    end
endmodule
